// file: core/cip_pkg.sv
package cip_pkg;

    localparam int unsigned DATA_W    = 32;
    localparam int unsigned OP_SEL_W  = 2;
    localparam int unsigned EXT_CNT_W = 16;
    localparam int unsigned CNT_W     = 3;

    // Operation codes on the select field
    localparam logic [OP_SEL_W-1:0] OP_BIT_SWAP  = 2'h0;
    localparam logic [OP_SEL_W-1:0] OP_BYTE_SWAP = 2'h1;
    localparam logic [OP_SEL_W-1:0] OP_HALF_SWAP = 2'h2;
    localparam logic [OP_SEL_W-1:0] OP_ADD       = 2'h3;

    // Fixed latency in cycles, chosen at system generation
    localparam int unsigned         LAT_CYC  = 4;
    localparam logic [CNT_W-1:0]    CNT_LOAD = CNT_W'(LAT_CYC - 2);

    localparam logic [DATA_W-1:0]    RESULT_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0]     CNT_RST    = 3'h0;
    localparam logic [EXT_CNT_W-1:0] EXT_RST    = 16'h0000;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } cip_state_t;

endpackage : cip_pkg

// file: core/cip_op_unit.sv
// Single-cycle operation unit; pure function of its operands and select
module cip_op_unit
    import cip_pkg::*;
(
    input  wire logic [OP_SEL_W-1:0] op_sel_in,  // Operation select
    input  wire logic [DATA_W-1:0]   dataa_in,   // First operand
    input  wire logic [DATA_W-1:0]   datab_in,   // Second operand
    output logic      [DATA_W-1:0]   result_out  // Selected result
);

    logic [DATA_W-1:0] bit_swap;
    logic [DATA_W-1:0] byte_swap;
    logic [DATA_W-1:0] half_swap;
    logic [DATA_W-1:0] sum;

    genvar i;
    generate
        for (i = 0; i < DATA_W; i++)
        begin : g_bit
            assign bit_swap[i] = dataa_in[DATA_W-1-i];
        end
    endgenerate

    assign byte_swap = {dataa_in[7:0], dataa_in[15:8], dataa_in[23:16], dataa_in[31:24]};
    assign half_swap = {dataa_in[15:0], dataa_in[31:16]};
    assign sum       = dataa_in + datab_in;

    // Output multiplexer steered by the select field
    always_comb
    begin
        case (op_sel_in)
            OP_BIT_SWAP:  result_out = bit_swap;
            OP_BYTE_SWAP: result_out = byte_swap;
            OP_HALF_SWAP: result_out = half_swap;
            OP_ADD:       result_out = sum;
            default:      result_out = RESULT_RST;
        endcase
    end

endmodule : cip_op_unit

// file: core/cip_custom_port.sv
// What this block does
// - The operation unit forms its result within one cycle from operands and select alone.
// - The result is the only required output and a single operand uses the first input.
// - The single-cycle unit has no connection outside the processor datapath.
// - A multi-cycle operation takes two or more cycles, fixed or by handshake.
// - The multi-cycle block has clock, clock enable and synchronous reset inputs.
// - A fixed n-cycle operation has its result valid by the edge n-1 after start.
// - Done and a valid result appear in the same cycle.
// - Edges while the clock enable is low change no state; a high synchronous reset still clears the block.
// - Ports beyond the instruction signals are external interface signals.
// - A select field of up to eight bits chooses the operation.
// - The select field steers an output multiplexer onto the result.
// - The select input is sized to the number of operations implemented.
module cip_custom_port
    import cip_pkg::*;
(
    input  wire logic                 sys_clk_in,    // System clock
    input  wire logic                 rst_b_in,      // Async reset, active low
    input  wire logic                 reset_in,      // Sync reset, active high
    input  wire logic                 clk_en_in,     // Clock qualifier
    input  wire logic                 start_in,      // Start of operation
    input  wire logic [OP_SEL_W-1:0]  n_in,          // Operation select
    input  wire logic [DATA_W-1:0]    dataa_in,      // First operand
    input  wire logic [DATA_W-1:0]    datab_in,      // Second operand
    output logic      [DATA_W-1:0]    result_out,    // Registered result
    output logic                      done_out,      // Completion pulse
    output logic      [EXT_CNT_W-1:0] ext_ops_out    // External count of ops
);

    cip_state_t          state_ff;
    cip_state_t          nxt_state;
    logic [CNT_W-1:0]    cnt_ff;
    logic [CNT_W-1:0]    nxt_cnt;
    logic [DATA_W-1:0]   result_ff;
    logic                done_ff;
    logic [EXT_CNT_W-1:0] ext_ops_ff;
    logic [DATA_W-1:0]   unit_result;
    logic                accept;
    logic                finish;

    // Operands and select are held by the processor for the whole operation
    cip_op_unit u_op_unit
    (
        .op_sel_in  (n_in),
        .dataa_in   (dataa_in),
        .datab_in   (datab_in),
        .result_out (unit_result)
    );

    assign accept = clk_en_in && start_in && (state_ff == ST_IDLE);
    assign finish = clk_en_in && (state_ff == ST_BUSY) && (cnt_ff == CNT_RST);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_state = ST_BUSY;
                    nxt_cnt   = CNT_LOAD;
                end
            end
            ST_BUSY:
            begin
                if (finish)
                begin
                    nxt_state = ST_IDLE;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_cnt   = CNT_RST;
            end
        endcase
    end

    // Sequencer; sync reset overrides, low enable freezes
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= CNT_RST;
        end
        else if (reset_in)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= CNT_RST;
        end
        else if (clk_en_in)
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Result captured in the same edge that raises done
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            result_ff <= RESULT_RST;
        end
        else if (reset_in)
        begin
            result_ff <= RESULT_RST;
        end
        else if (finish)
        begin
            result_ff <= unit_result;
        end
    end

    // Done pulse: one enabled cycle
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            done_ff <= 1'b0;
        end
        else if (reset_in)
        begin
            done_ff <= 1'b0;
        end
        else if (clk_en_in)
        begin
            done_ff <= finish;
        end
    end

    // Count of completed operations, routed to logic outside the processor
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ext_ops_ff <= EXT_RST;
        end
        else if (reset_in)
        begin
            ext_ops_ff <= EXT_RST;
        end
        else if (finish)
        begin
            ext_ops_ff <= ext_ops_ff + 16'h0001;
        end
    end

    assign result_out  = result_ff;
    assign done_out    = done_ff;
    assign ext_ops_out = ext_ops_ff;

    a_done_one_pulse: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (done_ff && clk_en_in && !reset_in) |=> !done_ff)
        else $error("done held longer than one enabled cycle");

    a_fixed_latency: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (accept && !reset_in) ##1 (clk_en_in && !reset_in)[*3] |=> done_ff)
        else $error("result not ready at fixed latency");

    a_min_two_cycles: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (accept && !reset_in) |=> (!done_ff ##1 !done_ff))
        else $error("operation finished in under two cycles");

    a_result_with_done: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        $rose(done_ff) |-> (result_out == $past(unit_result)))
        else $error("result not valid with done");

    a_enable_freeze: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!clk_en_in && !reset_in) |=> ($stable(state_ff) && $stable(cnt_ff)
                                       && $stable(done_ff) && $stable(result_ff)))
        else $error("state moved while clock enable low");

    a_sync_reset: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        reset_in |=> (state_ff == ST_IDLE && !done_ff && result_out == RESULT_RST))
        else $error("sync reset not honoured");

    a_op_mux_half: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (n_in == OP_HALF_SWAP) |-> (unit_result == {dataa_in[15:0], dataa_in[31:16]}))
        else $error("select does not steer result");

    a_ext_count: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (finish && !reset_in) |=> (ext_ops_out == $past(ext_ops_out) + 16'h0001))
        else $error("external count missed an operation");

    a_ext_hold: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!finish && !reset_in) |=> $stable(ext_ops_out))
        else $error("external count moved without a completion");

    a_done_when_idle: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        done_ff |-> (state_ff == ST_IDLE))
        else $error("done raised while still busy");

    a_result_hold: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!finish && !reset_in) |=> $stable(result_out))
        else $error("result changed without a completion");

    a_busy_kept: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_ff == ST_BUSY && !finish && !reset_in) |=> (state_ff == ST_BUSY))
        else $error("busy operation cut short");

    a_state_onehot: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        $onehot(state_ff))
        else $error("sequencer state not one-hot");

endmodule : cip_custom_port

// file: verification/cip_cpu_model.sv
module cip_cpu_model
    import cip_pkg::*;
(
    input  wire logic                sys_clk_in, // Clock
    input  wire logic                done_in,    // Completion
    output logic                     start_out,  // Start
    output logic      [OP_SEL_W-1:0] n_out,      // Select
    output logic      [DATA_W-1:0]   dataa_out,  // Operand a
    output logic      [DATA_W-1:0]   datab_out,  // Operand b
    output logic                     clk_en_out  // Qualifier
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        start_out = 1'b0;
        n_out = '0;
        dataa_out = '0;
        datab_out = '0;
        clk_en_out = 1'b1;
    end

    task automatic issue(input logic [1:0] op, input logic [31:0] a, b,
                         input logic [7:0] stall, input logic poke,
                         output int cyc, output logic seen);
        logic en;
        start_out = 1'b1;
        n_out = op;
        dataa_out = a;
        datab_out = b;
        clk_en_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        // A start while busy must be ignored
        start_out = poke;
        cyc = 0;
        for (int k = 0; k < 40 && done_in !== 1'b1; k++)
        begin
            clk_en_out = ~stall[k % 8];
            en = clk_en_out;
            @(posedge sys_clk_in);
            #1;
            start_out = 1'b0;
            if (en)
                cyc++;
        end
        seen = (done_in === 1'b1);
        // Released operands no longer show the old value
        dataa_out = ~dataa_out;
        datab_out = ~datab_out;
        n_out = ~n_out;
        clk_en_out = 1'b1;
    endtask : issue
endmodule : cip_cpu_model

// file: verification/testbench.sv
module testbench
    import cip_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 sys_clk, rst_b, reset, start, done, en;
    logic [OP_SEL_W-1:0]  n;
    logic [DATA_W-1:0]    a, b, res;
    logic [EXT_CNT_W-1:0] ops;
    logic [31:0]          seed = 32'h0000_2eec;
    int fail_count = 0;
    int compares = 0;
    int exp_ops = 0;

    cip_custom_port DUT (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .reset_in(reset),
        .clk_en_in(en), .start_in(start), .n_in(n), .dataa_in(a), .datab_in(b),
        .result_out(res), .done_out(done), .ext_ops_out(ops));
    cip_cpu_model CPU (.sys_clk_in(sys_clk), .done_in(done), .start_out(start),
        .n_out(n), .dataa_out(a), .datab_out(b), .clk_en_out(en));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] calc(input logic [1:0] op, input logic [31:0] x, y);
        logic [31:0] r;
        case (op)
            OP_BIT_SWAP:  for (int i = 0; i < 32; i++) r[i] = x[31-i];
            OP_BYTE_SWAP: r = {x[7:0], x[15:8], x[23:16], x[31:24]};
            OP_HALF_SWAP: r = {x[15:0], x[31:16]};
            default:      r = x + y;
        endcase
        return r;
    endfunction : calc

    task automatic complete_run();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic chk_val(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_bit(input string nm, input logic e, g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %0s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic run_op(input logic [1:0] op, input logic [31:0] x, y,
                          input logic [7:0] stall, input logic poke);
        int cyc;
        logic seen;
        fork
            CPU.issue(op, x, y, stall, poke, cyc, seen);
            begin
                @(posedge sys_clk);
                chk_val("comb result", calc(op, x, y), DUT.unit_result);
            end
        join
        if (seen !== 1'b1)
        begin
            fail_count++;
            complete_run();
        end
        exp_ops++;
        chk_val("result", calc(op, x, y), res);
        chk_val("edges", 32'(LAT_CYC - 1), 32'(cyc));
        chk_val("op count", 32'(exp_ops), {16'h0000, ops});
        @(posedge sys_clk);
        #1;
        chk_bit("done drop", 1'b0, done);
    endtask : run_op

    initial
    begin
        int cyc;
        logic seen;
        logic [31:0] r;
        rst_b = 1'b0;
        reset = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        for (int k = 0; k < 4; k++)
            run_op(2'(k), 32'h8765_4321, 32'h789a_bcdf, 8'h00, 1'b1);
        $display("test all ops done");
        repeat (20)
        begin
            r = rnd();
            run_op(r[1:0], rnd(), rnd(), r[15:8] & 8'h5a, r[2]);
        end
        $display("test random done");
        fork
            CPU.issue(2'h3, 32'h0000_0001, 32'h0000_0002, 8'h00, 1'b0, cyc, seen);
            begin
                repeat (2) @(posedge sys_clk);
                #1 reset = 1'b1;
                @(posedge sys_clk);
                #1 reset = 1'b0;
                chk_val("reset result", 32'h0000_0000, res);
                chk_val("reset count", 32'h0000_0000, {16'h0000, ops});
            end
        join
        chk_bit("done after reset", 1'b0, seen);
        $display("test sync reset done");
        complete_run();
    end
endmodule : testbench
